//--- verilog/ftc_trap_ctrl.sv
// Purpose: Trap enable, flush and rounding control register with trap raising.
// Assumes: The core writes by coprocessor index; datapath causes are synchronous.
// Notes:   Writable fields hold no reset; software programs them before use.
`timescale 1ns/10ps
module ftc_trap_ctrl (
   input  wire logic                         clk_sys,
   input  wire logic                         resetn,
   input  wire logic                         regWrite,
   input  wire logic [4:0]                   regIndex,
   input  wire logic [ftc_pkg::FTC_DATA_W-1:0] regWdata,
   output logic [ftc_pkg::FTC_DATA_W-1:0]    regRdata,
   input  wire logic                         causeValid,
   input  wire logic [ftc_pkg::FTC_NUM_EXC-1:0] causeBits,
   input  wire logic                         statusWrite,
   input  wire logic [ftc_pkg::FTC_NUM_EXC-1:0] statusCause,
   input  wire logic                         opValid,
   input  wire logic                         denormIn,
   input  wire logic                         tinyOut,
   input  wire logic                         resultNeg,
   output logic                              trapTaken,
   output logic [ftc_pkg::FTC_NUM_EXC-1:0]   trapCause,
   output logic                              flushOut,
   output ftc_pkg::ftc_round_t               roundOut,
   output logic                              zeroOperand,
   output logic                              unimplOp,
   output ftc_pkg::ftc_tiny_t                tinyAction
);
   import ftc_pkg::*;

   typedef struct packed {
      logic [FTC_DATA_W-1:0]  ctl;
      logic [FTC_DATA_W-1:0]  rdata;
      logic                   trap;
      logic [FTC_NUM_EXC-1:0] cause;
   } ftc_ctl_state_t;

   ftc_ctl_state_t s_q;
   ftc_ctl_state_t s_d;

   logic [FTC_NUM_EXC-1:0] exceptionTrapMask;
   logic [FTC_NUM_EXC-1:0] hitArith;
   logic [FTC_NUM_EXC-1:0] hitStatus;
   logic [FTC_NUM_EXC-1:0] hitAll;
   logic                   ctlSel;
   ftc_mode_if             modeBus ();

   assign ctlSel            = (regIndex == FTC_CTL_INDEX);
   assign exceptionTrapMask = s_q.ctl[FTC_EN_MSB:FTC_EN_LSB];

   genvar g;
   generate
      for (g = 0; g < FTC_NUM_EXC; g++) begin : g_exc
         assign hitArith[g]  = causeValid && causeBits[g] && exceptionTrapMask[g];
         assign hitStatus[g] = statusWrite && statusCause[g] && exceptionTrapMask[g];

         property p_arith_bit;
            @(posedge clk_sys) disable iff (!resetn)
            causeValid && causeBits[g] && exceptionTrapMask[g] |=> trapCause[g];
         endproperty
         a_arith_bit: assert property (p_arith_bit) else $error("Arithmetic cause bit lost");
         property p_status_bit;
            @(posedge clk_sys) disable iff (!resetn)
            statusWrite && statusCause[g] && exceptionTrapMask[g] |=> trapCause[g];
         endproperty
         a_status_bit: assert property (p_status_bit) else $error("Status cause bit lost");
      end
   endgenerate

   // The enable field must hold exactly one bit per exception cause.
   if (FTC_EN_MSB - FTC_EN_LSB + 1 != FTC_NUM_EXC) begin : g_bad_field
      $error("Enable field width does not match the cause count");
   end
   assign hitAll = hitArith | hitStatus;

   always_comb begin
      s_d       = s_q;
      if (regWrite && ctlSel) begin
         // Only the enable, flush and rounding fields take the written value.
         s_d.ctl = regWdata & FTC_WR_MASK;
      end
      s_d.rdata = (ctlSel ? s_d.ctl : FTC_RESET_VAL) & FTC_WR_MASK;
      s_d.trap  = |hitAll;
      s_d.cause = hitAll;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         // Control fields stay out of reset, so they power up unknown and keep their value.
         s_q.rdata <= FTC_RESET_VAL;
         s_q.trap  <= 1'b0;
         s_q.cause <= FTC_CAUSE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign modeBus.flushOn  = s_q.ctl[FTC_FLUSH_BIT];
   assign modeBus.roundSel = ftc_round_t'(s_q.ctl[FTC_RM_MSB:FTC_RM_LSB]);

   ftc_operand_policy u_policy (
      .clk_sys     (clk_sys),
      .resetn      (resetn),
      .mode        (modeBus),
      .opValid     (opValid),
      .denormIn    (denormIn),
      .tinyOut     (tinyOut),
      .resultNeg   (resultNeg),
      .zeroOperand (zeroOperand),
      .unimplOp    (unimplOp),
      .tinyAction  (tinyAction)
   );

   assign regRdata  = s_q.rdata;
   assign trapTaken = s_q.trap;
   assign trapCause = s_q.cause;
   assign flushOut  = s_q.ctl[FTC_FLUSH_BIT];
   assign roundOut  = ftc_round_t'(s_q.ctl[FTC_RM_MSB:FTC_RM_LSB]);

   property p_reserved_zero;
      @(posedge clk_sys) disable iff (!resetn)
      (regRdata & ~FTC_WR_MASK) == 32'h0000_0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits nonzero");

   property p_readback;
      @(posedge clk_sys) disable iff (!resetn)
      regWrite && ctlSel ##1 !regWrite && ctlSel |=> regRdata == ($past(regWdata, 2) & FTC_WR_MASK);
   endproperty
   a_readback: assert property (p_readback) else $error("Readback mismatch");

   property p_trap_enabled;
      @(posedge clk_sys) disable iff (!resetn)
      causeValid && |(causeBits & exceptionTrapMask) |=> trapTaken;
   endproperty
   a_trap_enabled: assert property (p_trap_enabled) else $error("Enabled trap missed");

   property p_trap_masked;
      @(posedge clk_sys) disable iff (!resetn)
      !(causeValid && |(causeBits & exceptionTrapMask))
      && !(statusWrite && |(statusCause & exceptionTrapMask)) |=> !trapTaken;
   endproperty
   a_trap_masked: assert property (p_trap_masked) else $error("Masked trap taken");

   property p_status_trap;
      @(posedge clk_sys) disable iff (!resetn)
      statusWrite && |(statusCause & exceptionTrapMask) |=> trapTaken && trapCause != 5'h00;
   endproperty
   a_status_trap: assert property (p_status_trap) else $error("Status write trap missed");

   property p_round_follow;
      @(posedge clk_sys) disable iff (!resetn)
      regWrite && ctlSel |=> roundOut == ftc_round_t'($past(regWdata[1:0]));
   endproperty
   a_round_follow: assert property (p_round_follow) else $error("Rounding field wrong");

   property p_write_readback;
      @(posedge clk_sys) disable iff (!resetn)
      regWrite && ctlSel |=> regRdata == ($past(regWdata) & FTC_WR_MASK);
   endproperty
   a_write_readback: assert property (p_write_readback) else $error("Write not read back");

   property p_flush_follow;
      @(posedge clk_sys) disable iff (!resetn)
      regWrite && ctlSel |=> flushOut == $past(regWdata[FTC_FLUSH_BIT]);
   endproperty
   a_flush_follow: assert property (p_flush_follow) else $error("Flush field wrong");

   property p_other_index_zero;
      @(posedge clk_sys) disable iff (!resetn)
      !ctlSel |=> regRdata == 32'h0000_0000;
   endproperty
   a_other_index_zero: assert property (p_other_index_zero) else $error("Other index nonzero");

   property p_other_write_ignored;
      @(posedge clk_sys) disable iff (!resetn)
      regWrite && !ctlSel |=> flushOut == $past(flushOut) && roundOut == $past(roundOut)
         && exceptionTrapMask == $past(exceptionTrapMask);
   endproperty
   a_other_write_ignored: assert property (p_other_write_ignored) else $error("Stray write landed");

   property p_cause_enabled_only;
      @(posedge clk_sys) disable iff (!resetn)
      causeValid || statusWrite |=> (trapCause & ~$past(exceptionTrapMask)) == 5'h00;
   endproperty
   a_cause_enabled_only: assert property (p_cause_enabled_only) else $error("Masked cause shown");

   property p_tiny_plus;
      @(posedge clk_sys) disable iff (!resetn)
      opValid && tinyOut && flushOut && roundOut == FTC_RM_PLUS && !resultNeg
      |=> tinyAction == FTC_TINY_SMALLEST_NORMAL_VALUE;
   endproperty
   a_tiny_plus: assert property (p_tiny_plus) else $error("Tiny plus wrong");

   property p_tiny_toward_zero;
      @(posedge clk_sys) disable iff (!resetn)
      opValid && tinyOut && flushOut && roundOut == FTC_RM_ZERO
      |=> tinyAction == FTC_TINY_ZERO;
   endproperty
   a_tiny_toward_zero: assert property (p_tiny_toward_zero) else $error("Tiny zero wrong");

   property p_tiny_keep;
      @(posedge clk_sys) disable iff (!resetn)
      opValid && tinyOut && !flushOut |=> tinyAction == FTC_TINY_KEEP;
   endproperty
   a_tiny_keep: assert property (p_tiny_keep) else $error("Tiny flushed without flush");

   property p_op_quiet;
      @(posedge clk_sys) disable iff (!resetn)
      !opValid |=> !zeroOperand && !unimplOp && tinyAction == FTC_TINY_KEEP;
   endproperty
   a_op_quiet: assert property (p_op_quiet) else $error("Policy active without op");

   property p_unimpl_needs_denorm;
      @(posedge clk_sys) disable iff (!resetn)
      !(opValid && denormIn) |=> !unimplOp;
   endproperty
   a_unimpl_needs_denorm: assert property (p_unimpl_needs_denorm) else $error("Spurious unimpl");
endmodule : ftc_trap_ctrl

//--- verilog/ftc_pkg.sv
// Purpose: Shared constants and types for the trap and rounding control block.
// Assumes: One 32-bit coprocessor control register, reached by index.
// Notes:   Writable fields power up unknown; reset clears only the trap flags, the read data and the zero/unimpl policy outputs, and sets the tiny action to keep.
package ftc_pkg;
   localparam int          FTC_DATA_W      = 32;
   localparam int          FTC_NUM_EXC     = 5;
   localparam logic [4:0]  FTC_CTL_INDEX   = 5'h1C;
   localparam int          FTC_EN_LSB      = 7;
   localparam int          FTC_EN_MSB      = 11;
   localparam int          FTC_FLUSH_BIT   = 2;
   localparam int          FTC_RM_LSB      = 0;
   localparam int          FTC_RM_MSB      = 1;
   localparam logic [31:0] FTC_WR_MASK     = 32'h0000_0F87;
   localparam logic [31:0] FTC_RESET_VAL   = 32'h0000_0000;
   localparam logic [4:0]  FTC_CAUSE_RESET = 5'h00;

   // Exception order matches the enable field, least significant first.
   localparam int FTC_EXC_INEXACT   = 0;
   localparam int FTC_EXC_UNDERFLOW = 1;
   localparam int FTC_EXC_OVERFLOW  = 2;
   localparam int FTC_EXC_DIVZERO   = 3;
   localparam int FTC_EXC_INVALID   = 4;

   typedef enum logic [1:0] {
      FTC_RM_NEAREST = 2'h0,
      FTC_RM_ZERO    = 2'h1,
      FTC_RM_PLUS    = 2'h2,
      FTC_RM_MINUS   = 2'h3
   } ftc_round_t;

   typedef enum logic [1:0] {
      FTC_TINY_ZERO    = 2'h0,
      FTC_TINY_SMALLEST_NORMAL_VALUE = 2'h1,
      FTC_TINY_KEEP    = 2'h3
   } ftc_tiny_t;
endpackage : ftc_pkg

//--- verilog/ftc_mode_if.sv
// Purpose: Carries the live mode settings from the register to the operand policy.
// Assumes: Single clock domain.
// Notes:   None.
`timescale 1ns/10ps
interface ftc_mode_if;
   import ftc_pkg::*;
   logic       flushOn;
   ftc_round_t roundSel;
   modport ctl (output flushOn, output roundSel);
   modport pol (input flushOn, input roundSel);
endinterface : ftc_mode_if

//--- verilog/ftc_operand_policy.sv
// Purpose: Decides denormal operand and tiny result handling from the modes.
// Assumes: Flags arrive with the operation they describe.
// Notes:   Outputs are registered, one cycle after the request.
`timescale 1ns/10ps
module ftc_operand_policy (
   input  wire logic                 clk_sys,
   input  wire logic                 resetn,
   ftc_mode_if.pol                   mode,
   input  wire logic                 opValid,
   input  wire logic                 denormIn,
   input  wire logic                 tinyOut,
   input  wire logic                 resultNeg,
   output logic                      zeroOperand,
   output logic                      unimplOp,
   output ftc_pkg::ftc_tiny_t        tinyAction
);
   import ftc_pkg::*;

   typedef struct packed {
      logic       zeroOp;
      logic       unimpl;
      ftc_tiny_t  tiny;
   } ftc_pol_state_t;

   ftc_pol_state_t s_q;
   ftc_pol_state_t s_d;

   always_comb begin
      s_d        = '{zeroOp: 1'b0, unimpl: 1'b0, tiny: FTC_TINY_KEEP};
      if (opValid && denormIn) begin
         s_d.zeroOp = mode.flushOn;
         s_d.unimpl = !mode.flushOn;
      end
      if (opValid && tinyOut && mode.flushOn) begin
         // Directed rounding away from zero lands on the smallest normal value.
         case (mode.roundSel)
            FTC_RM_PLUS:  s_d.tiny = resultNeg ? FTC_TINY_ZERO : FTC_TINY_SMALLEST_NORMAL_VALUE;
            FTC_RM_MINUS: s_d.tiny = resultNeg ? FTC_TINY_SMALLEST_NORMAL_VALUE : FTC_TINY_ZERO;
            default:      s_d.tiny = FTC_TINY_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s_q <= '{zeroOp: 1'b0, unimpl: 1'b0, tiny: FTC_TINY_KEEP};
      end else begin
         s_q <= s_d;
      end
   end

   assign zeroOperand = s_q.zeroOp;
   assign unimplOp    = s_q.unimpl;
   assign tinyAction  = s_q.tiny;

   property p_flush_operand;
      @(posedge clk_sys) disable iff (!resetn)
      opValid && denormIn |=> (zeroOperand == $past(mode.flushOn)) && (unimplOp != zeroOperand);
   endproperty
   a_flush_operand: assert property (p_flush_operand) else $error("Denormal policy wrong");

   property p_no_flush_unimpl;
      @(posedge clk_sys) disable iff (!resetn)
      opValid && denormIn && !mode.flushOn |=> unimplOp;
   endproperty
   a_no_flush_unimpl: assert property (p_no_flush_unimpl) else $error("Missing unimpl");

   property p_tiny_minus;
      @(posedge clk_sys) disable iff (!resetn)
      opValid && tinyOut && mode.flushOn && mode.roundSel == FTC_RM_MINUS && resultNeg
      |=> tinyAction == FTC_TINY_SMALLEST_NORMAL_VALUE;
   endproperty
   a_tiny_minus: assert property (p_tiny_minus) else $error("Tiny minus wrong");

   property p_tiny_near;
      @(posedge clk_sys) disable iff (!resetn)
      opValid && tinyOut && mode.flushOn && mode.roundSel == FTC_RM_NEAREST
      |=> tinyAction == FTC_TINY_ZERO;
   endproperty
   a_tiny_near: assert property (p_tiny_near) else $error("Tiny nearest wrong");
endmodule : ftc_operand_policy

//--- sim/ftc_core_model.sv
// Purpose: Core and datapath stand-in that drives the trap and rounding control block.
// Assumes: Requests change at the falling edge and are taken at the next rising edge.
// Notes:   Released data lines show the inverse of their last value.
`timescale 1ns/10ps
module ftc_core_model (
   input  wire logic        clk_sys,
   output logic             regWrite,
   output logic [4:0]       regIndex,
   output logic [31:0]      regWdata,
   output logic             causeValid,
   output logic [4:0]       causeBits,
   output logic             statusWrite,
   output logic [4:0]       statusCause,
   output logic             opValid,
   output logic [2:0]       opFlags
);
   initial begin
      regWrite = 1'b0;
      regIndex = 5'h1C;
      regWdata = 32'h0;
      causeValid = 1'b0;
      causeBits = 5'h0;
      statusWrite = 1'b0;
      statusCause = 5'h0;
      opValid = 1'b0;
      opFlags = 3'h0;
   end

   // Index stays on the control register between accesses so the read port shows it.
   task automatic xfer(input logic w, input logic [4:0] idx, input logic [31:0] d);
      @(negedge clk_sys);
      regWrite = w;
      regIndex = idx;
      regWdata = d;
      @(negedge clk_sys);
      regWrite = 1'b0;
      regIndex = 5'h1C;
      regWdata = ~d;
   endtask : xfer

   task automatic cause(input logic arith, input logic [4:0] bits);
      @(negedge clk_sys);
      causeValid = arith;
      statusWrite = ~arith;
      causeBits = bits;
      statusCause = bits;
      @(negedge clk_sys);
      causeValid = 1'b0;
      statusWrite = 1'b0;
      causeBits = ~bits;
      statusCause = ~bits;
   endtask : cause

   task automatic op(input logic [2:0] fl);
      @(negedge clk_sys);
      opValid = 1'b1;
      opFlags = fl;
      @(negedge clk_sys);
      opValid = 1'b0;
      opFlags = ~fl;
   endtask : op
endmodule : ftc_core_model

//--- sim/fpu_trap_and_rounding_control_tb.sv
// Purpose: Self-checking bench for the trap and rounding control block.
// Assumes: Inputs change at the falling clock edge; outputs are registered.
// Notes:   Policy table entries are {mode bits 2:0, denorm/tiny/neg, zero/unimpl/tiny}.
`timescale 1ns/10ps
module fpu_trap_and_rounding_control_tb;
   import ftc_pkg::*;
   logic             clk_sys = 1'b0;
   logic             resetn = 1'b0;
   logic             regWrite, causeValid, statusWrite, opValid;
   logic [4:0]       regIndex, causeBits, statusCause, trapCause;
   logic [31:0]      regWdata, regRdata;
   logic [2:0]       opFlags;
   logic             trapTaken, flushOut, zeroOperand, unimplOp;
   ftc_round_t       roundOut;
   ftc_tiny_t        tinyAction;
   int               errors = 0;
   int               testsRun = 0;
   localparam logic [9:0] POL_TBL [9] = '{{3'h0, 3'h4, 4'h7}, {3'h4, 3'h4, 4'hB},
      {3'h6, 3'h2, 4'h1}, {3'h6, 3'h3, 4'h0}, {3'h7, 3'h2, 4'h0}, {3'h7, 3'h3, 4'h1},
      {3'h4, 3'h2, 4'h0}, {3'h5, 3'h3, 4'h0}, {3'h2, 3'h2, 4'h3}};

   always #50 clk_sys = ~clk_sys;

   ftc_core_model md (.clk_sys(clk_sys), .regWrite(regWrite), .regIndex(regIndex),
      .regWdata(regWdata), .causeValid(causeValid), .causeBits(causeBits),
      .statusWrite(statusWrite), .statusCause(statusCause), .opValid(opValid),
      .opFlags(opFlags));

   ftc_trap_ctrl i_dut (.clk_sys(clk_sys), .resetn(resetn), .regWrite(regWrite),
      .regIndex(regIndex), .regWdata(regWdata), .regRdata(regRdata),
      .causeValid(causeValid), .causeBits(causeBits), .statusWrite(statusWrite),
      .statusCause(statusCause), .opValid(opValid), .denormIn(opFlags[2]),
      .tinyOut(opFlags[1]), .resultNeg(opFlags[0]), .trapTaken(trapTaken),
      .trapCause(trapCause), .flushOut(flushOut), .roundOut(roundOut),
      .zeroOperand(zeroOperand), .unimplOp(unimplOp), .tinyAction(tinyAction));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic endSim;
      $display("Counts: %0d compared, %0d wrong", testsRun, errors);
      if (errors == 0 && testsRun > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : endSim

   task automatic testFields;
      md.xfer(1'b1, 5'h1C, 32'hFFFF_FFFF);
      chk(regRdata, 32'h0000_0F87);
      chk(32'({flushOut, roundOut}), 32'h7);
      md.xfer(1'b1, 5'h1B, 32'h0);
      chk(regRdata, 32'h0);
      chk(32'({flushOut, roundOut}), 32'h7);
      md.xfer(1'b0, 5'h1B, 32'h0);
      chk(regRdata, 32'h0);
      md.xfer(1'b1, 5'h1C, 32'hFFFF_F078);
      chk(regRdata, 32'h0);
      chk(32'({flushOut, roundOut}), 32'h0);
      $display("test fields done");
   endtask : testFields

   task automatic testRound;
      for (int m = 0; m < 4; m++) begin
         md.xfer(1'b1, 5'h1C, 32'h4 | 32'(m));
         chk(32'(roundOut), 32'(m));
         chk(32'(flushOut), 32'h1);
      end
      $display("test round done");
   endtask : testRound

   task automatic testTrap;
      for (int i = 0; i < 5; i++) begin
         md.xfer(1'b1, 5'h1C, 32'h1 << (7 + i));
         md.cause(1'b1, 5'h1F);
         chk(32'({trapTaken, trapCause}), 32'h20 | (32'h1 << i));
         md.cause(1'b1, 5'(~(5'h1 << i)));
         chk(32'(trapTaken), 32'h0);
         md.cause(1'b0, 5'(5'h1 << i));
         chk(32'({trapTaken, trapCause}), 32'h20 | (32'h1 << i));
      end
      $display("test trap done");
   endtask : testTrap

   task automatic testPolicy;
      for (int k = 0; k < 9; k++) begin
         md.xfer(1'b1, 5'h1C, {29'h0, POL_TBL[k][9:7]});
         md.op(POL_TBL[k][6:4]);
         chk({28'h0, zeroOperand, unimplOp, tinyAction}, {28'h0, POL_TBL[k][3:0]});
      end
      $display("test policy done");
   endtask : testPolicy

   initial begin
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(32'({trapTaken, trapCause, zeroOperand, unimplOp}), 32'h0);
      chk(32'(tinyAction), 32'(FTC_TINY_KEEP));
      chk(regRdata, 32'h0);
      resetn = 1'b1;
      testFields();
      testRound();
      testTrap();
      testPolicy();
      endSim();
   end

   initial begin
      repeat (3000) @(posedge clk_sys);
      errors++;
      endSim();
   end
endmodule : fpu_trap_and_rounding_control_tb
